//--- hw/lcs_control.sv
// Functional notes
// - Reset input held 5 s during non-critical lockout returns to normal.
// - Reset input held beyond 10 s re-enters failure lockout.
// - Reset input ignored in critical lockout; only power cycle clears it.
// - After reset, a still-present failure re-enters lockout.
// - Monitor compares feedback contact with safety outputs when enabled.
// - Feedback tested no sooner than 350 ms after outputs go on.
// - Feedback tested no sooner than 100 ms after outputs go off.
// - Code input sampled once at startup selects emission code.
// - Test input held 0.5 s disables emission.
// - Disabled emission breaks all beams; outputs then go off.
// - Test held 2 s to 5 s toggles emission range.
// - Selected range is kept in nonvolatile storage.
// - Automatic restart turns outputs on after object leaves and recovery.
// - Manual restart needs restart held 0.5 s and recovery time.
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module lcs_control
  import lcs_pkg::*;
#(
  // Clock cycles per millisecond tick
  parameter int unsigned TICK_CYCLES = MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire lcs_bus_t bus,
  output logic [31:0] rdata,
  input wire logic reset_in,
  input wire logic test_in,
  input wire logic restart_in,
  input wire lcs_code_pin_t code_pin,
  input wire logic beams_clear,
  input wire logic failure_present,
  input wire logic feedback_nc,
  input wire logic range_nv_in,
  output logic range_nv_out,
  output logic range_nv_wr,
  output logic safety_output_pair,
  output logic emission_en,
  output logic range_long,
  output lcs_code_t emission_code_one,
  output logic irq
);

  // ----------------------------------------------------------------------
  // Millisecond time base
  // ----------------------------------------------------------------------
  localparam int unsigned TICK_W = $clog2(TICK_CYCLES);
  logic [TICK_W-1:0] tick_reg;
  logic ms_tick;

  always_ff @(posedge clk_sys) begin
    if (rst || tick_reg == TICK_W'(TICK_CYCLES - 1)) begin
      tick_reg <= '0;
    end else begin
      tick_reg <= tick_reg + 1'b1;
    end
  end
  assign ms_tick = (tick_reg == TICK_W'(TICK_CYCLES - 1));

  // Saturating millisecond count while a level is held
  function automatic logic [13:0] hold_ms(input logic lvl,
                                          input logic [13:0] cnt,
                                          input logic tick);
    if (!lvl) begin
      hold_ms = '0;
    end else if (tick && cnt != 14'h3FFF) begin
      hold_ms = cnt + 1'b1;
    end else begin
      hold_ms = cnt;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_en_reg;
  logic [IRQ_W-1:0] ev;
  logic fb_en;
  logic manual_mode;
  logic crit;
  logic range_opt;
  assign fb_en = ctrl_reg[CTRL_FB_EN_BIT];
  assign manual_mode = ctrl_reg[CTRL_MANUAL_BIT];
  assign crit = ctrl_reg[CTRL_CRIT_BIT];
  assign range_opt = ctrl_reg[CTRL_RANGE_OPT_BIT];

  // Control register write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
    end else if (bus.wr && bus.addr == ADDR_CTRL) begin
      ctrl_reg <= bus.wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Lockout state machine
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    LCS_ST_BOOT,
    LCS_ST_RUN,
    LCS_ST_LOCK,
    LCS_ST_WAIT_REL
  } lcs_state_t;

  lcs_state_t state_reg;
  logic crit_lock_reg;
  logic [13:0] rst_hold_reg;
  logic fb_fault;

  always_ff @(posedge clk_sys) begin
    rst_hold_reg <= rst ? '0 : hold_ms(reset_in, rst_hold_reg, ms_tick);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_reg <= LCS_ST_BOOT;
      crit_lock_reg <= 1'b0;
    end else begin
      case (state_reg)
        LCS_ST_BOOT: begin
          // Failure still present after power cycle locks again
          if (failure_present) begin
            state_reg <= LCS_ST_LOCK;
            crit_lock_reg <= crit;
          end else begin
            state_reg <= LCS_ST_RUN;
          end
        end
        LCS_ST_RUN: begin
          if (failure_present || fb_fault) begin
            state_reg <= LCS_ST_LOCK;
            crit_lock_reg <= crit && failure_present;
          end
        end
        LCS_ST_LOCK: begin
          // Only non-critical lockout listens to the reset input
          // A hold already past the upper limit must be released first
          if (!crit_lock_reg && rst_hold_reg >= 14'(RESET_MIN_MS)
              && rst_hold_reg <= 14'(RESET_MAX_MS)) begin
            state_reg <= LCS_ST_WAIT_REL;
          end
        end
        LCS_ST_WAIT_REL: begin
          if (rst_hold_reg > 14'(RESET_MAX_MS)) begin
            state_reg <= LCS_ST_LOCK;
          end else if (!reset_in) begin
            state_reg <= LCS_ST_BOOT;
          end
        end
        default: state_reg <= LCS_ST_BOOT;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Test input: emission disable and range toggle
  // ----------------------------------------------------------------------
  logic [13:0] test_hold_reg;
  logic range_reg;
  logic range_loaded_reg;
  logic test_prev_reg;

  always_ff @(posedge clk_sys) begin
    test_hold_reg <= rst ? '0 : hold_ms(test_in, test_hold_reg, ms_tick);
    test_prev_reg <= rst ? 1'b0 : test_in;
  end

  // Range loaded from storage at startup, toggled on release in 2..5 s
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      range_reg <= 1'b0;
      range_loaded_reg <= 1'b0;
      range_nv_wr <= 1'b0;
      range_nv_out <= 1'b0;
    end else begin
      range_nv_wr <= 1'b0;
      if (!range_loaded_reg) begin
        range_reg <= range_nv_in;
        range_loaded_reg <= 1'b1;
      end else if (range_opt && test_prev_reg && !test_in
                   && test_hold_reg > 14'(RANGE_MIN_MS)
                   && test_hold_reg < 14'(RANGE_MAX_MS)) begin
        range_reg <= !range_reg;
        range_nv_out <= !range_reg;
        range_nv_wr <= 1'b1;
      end
    end
  end

  // Emission enable drops after 0.5 s of
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      emission_en <= 1'b0;
      range_long <= 1'b0;
    end else begin
      emission_en <= (state_reg == LCS_ST_RUN)
                     && test_hold_reg < 14'(TEST_MS);
      range_long <= range_reg;
    end
  end

  // Emission code caught once after reset release
  logic code_done_reg;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      code_done_reg <= 1'b0;
      emission_code_one <= LCS_CODE_NONE;
    end else if (!code_done_reg) begin
      code_done_reg <= 1'b1;
      if (code_pin.to_common) begin
        emission_code_one <= LCS_CODE_ONE;
      end else if (code_pin.to_supply) begin
        emission_code_one <= LCS_CODE_TWO;
      end else begin
        emission_code_one <= LCS_CODE_NONE;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Restart and safety outputs
  // ----------------------------------------------------------------------
  logic [13:0] clear_ms_reg;
  logic [13:0] restart_hold_reg;
  logic restart_ok_reg;
  logic beams_ok;

  // Beams seen clear only while emission runs
  assign beams_ok = beams_clear && emission_en;

  always_ff @(posedge clk_sys) begin
    clear_ms_reg <= rst ? '0 : hold_ms(beams_ok, clear_ms_reg, ms_tick);
    restart_hold_reg <= rst ? '0
                        : hold_ms(restart_in, restart_hold_reg, ms_tick);
  end

  // Manual restart armed by a 0.5 s press with the area clear
  always_ff @(posedge clk_sys) begin
    if (rst || !beams_ok) begin
      restart_ok_reg <= 1'b0;
    end else if (restart_hold_reg >= 14'(RESTART_MS)) begin
      restart_ok_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      safety_output_pair <= 1'b0;
    end else if (state_reg != LCS_ST_RUN || !beams_ok || fb_fault) begin
      safety_output_pair <= 1'b0;
    end else if (clear_ms_reg >= 14'(RECOVERY_MS)
                 && (!manual_mode || restart_ok_reg)) begin
      safety_output_pair <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Contactor feedback monitor
  // ----------------------------------------------------------------------
  logic out_prev_reg;
  logic [9:0] fb_ms_reg;
  logic fb_pending_reg;
  logic fb_fault_check;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_prev_reg <= 1'b0;
      fb_ms_reg <= '0;
      fb_pending_reg <= 1'b0;
    end else begin
      out_prev_reg <= safety_output_pair;
      // A new output change beats the end of the previous test
      if (fb_pending_reg && fb_fault_check) begin
        fb_pending_reg <= 1'b0;
      end
      if (out_prev_reg != safety_output_pair) begin
        fb_ms_reg <= '0;
        fb_pending_reg <= 1'b1;
      end else if (fb_pending_reg && ms_tick) begin
        fb_ms_reg <= fb_ms_reg + 1'b1;
      end
    end
  end

  // Test point: on needs 350 ms, off needs 100 ms
  assign fb_fault_check = fb_pending_reg
    && (out_prev_reg ? fb_ms_reg >= 10'(FB_ON_MS)
                     : fb_ms_reg >= 10'(FB_OFF_MS));
  // Closed contact expected with outputs off, open with outputs on
  assign fb_fault = fb_en && fb_fault_check
                    && (feedback_nc == out_prev_reg);

  // ----------------------------------------------------------------------
  // Interrupts and read data
  // ----------------------------------------------------------------------
  lcs_state_t state_prev_reg;
  always_ff @(posedge clk_sys) begin
    state_prev_reg <= rst ? LCS_ST_BOOT : state_reg;
  end

  always_comb begin
    ev = '0;
    ev[EV_LOCK] = state_reg == LCS_ST_LOCK && state_prev_reg != LCS_ST_LOCK;
    ev[EV_UNLOCK] = state_reg == LCS_ST_WAIT_REL
                    && state_prev_reg == LCS_ST_LOCK;
    ev[EV_FB_FAULT] = fb_fault;
    ev[EV_RANGE] = range_nv_wr;
    ev[EV_TEST] = test_hold_reg == 14'(TEST_MS) && ms_tick;
  end

  // Sticky status: a new event beats a simultaneous clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_stat_reg <= '0;
      irq_en_reg <= '0;
    end else begin
      if (bus.wr && bus.addr == ADDR_IRQ_CLR) begin
        irq_stat_reg <= (irq_stat_reg & ~bus.wdata[IRQ_W-1:0]) | ev;
      end else begin
        irq_stat_reg <= irq_stat_reg | ev;
      end
      if (bus.wr && bus.addr == ADDR_IRQ_EN) begin
        irq_en_reg <= bus.wdata[IRQ_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    irq <= rst ? 1'b0 : |(irq_stat_reg & irq_en_reg);
  end

  // Read data valid the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys) begin
    if (rst || !bus.rd) begin
      rdata <= '0;
    end else begin
      case (bus.addr)
        ADDR_CTRL: rdata <= ctrl_reg;
        ADDR_STATUS: rdata <= {24'h000000, emission_code_one,
                               range_reg, crit_lock_reg,
                               safety_output_pair, emission_en,
                               state_reg};
        ADDR_IRQ_STAT: rdata <= {27'h0000000, irq_stat_reg};
        ADDR_IRQ_EN: rdata <= {27'h0000000, irq_en_reg};
        default: rdata <= '0;
      endcase
    end
  end

endmodule

`default_nettype wire

//--- shared/lcs_pkg.sv
package lcs_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned RESET_MIN_MS = 5000;
  localparam int unsigned RESET_MAX_MS = 10000;
  localparam int unsigned FB_ON_MS = 350;
  localparam int unsigned FB_OFF_MS = 100;
  localparam int unsigned TEST_MS = 500;
  localparam int unsigned RANGE_MIN_MS = 2000;
  localparam int unsigned RANGE_MAX_MS = 5000;
  localparam int unsigned RESTART_MS = 500;
  localparam int unsigned RECOVERY_MS = 100;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;

  // ----------------------------------------------------------------------
  // Register map (word addresses on byte offsets)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int unsigned CTRL_FB_EN_BIT = 0;
  localparam int unsigned CTRL_MANUAL_BIT = 1;
  localparam int unsigned CTRL_CRIT_BIT = 2;
  localparam int unsigned CTRL_RANGE_OPT_BIT = 3;

  // Interrupt events
  localparam int unsigned IRQ_W = 5;
  localparam int unsigned EV_LOCK = 0;
  localparam int unsigned EV_UNLOCK = 1;
  localparam int unsigned EV_FB_FAULT = 2;
  localparam int unsigned EV_RANGE = 3;
  localparam int unsigned EV_TEST = 4;

  // Emission codes
  typedef enum logic [1:0] {
    LCS_CODE_NONE = 2'h0,
    LCS_CODE_ONE = 2'h1,
    LCS_CODE_TWO = 2'h2
  } lcs_code_t;

  // Level of the code input at startup
  typedef struct packed {
    logic to_common;
    logic to_supply;
  } lcs_code_pin_t;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } lcs_bus_t;

endpackage

//--- testbench/lcs_control_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checker of the safety control block
// ------------------------------------------------------------
module lcs_control_assertions
  import lcs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire lcs_bus_t bus,
  input wire logic [31:0] rdata,
  input wire logic beams_clear,
  input wire logic failure_present,
  input wire logic range_nv_out,
  input wire logic range_nv_wr,
  input wire logic safety_output_pair,
  input wire logic range_long,
  input wire lcs_code_t emission_code_one,
  input wire logic irq
);
  localparam int unsigned CLR_MIN = (RECOVERY_MS - 1) * TICK_CYCLES;
  logic [31:0] clr_cnt_reg;
  logic en_wr;
  logic en_off;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Cycles in a row with every beam received
  always_ff @(posedge clk_sys) begin
    if (rst || !beams_clear) begin
      clr_cnt_reg <= 32'h0;
    end else begin
      clr_cnt_reg <= clr_cnt_reg + 32'h1;
    end
  end
  // Writes to the interrupt enable, and those that mask all
  assign en_wr = bus.wr && (bus.addr == ADDR_IRQ_EN);
  assign en_off = en_wr && (bus.wdata[IRQ_W-1:0] == '0);
  property p_rdata_idle;
    !$past(bus.rd) |-> rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside a read cycle");
  property p_irq_masked;
    en_off ##1 !en_wr |-> ##1 !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt high with all sources masked");
  property p_code_stable;
    !$past(rst) && !$past(rst, 2) && !$past(rst, 3)
      |-> $stable(emission_code_one);
  endproperty
  a_code_stable: assert property (p_code_stable)
    else $error("emission code changed after startup");
  property p_rise_after_clear;
    $rose(safety_output_pair) |-> clr_cnt_reg >= CLR_MIN;
  endproperty
  a_rise_after_clear: assert property (p_rise_after_clear)
    else $error("outputs on before recovery time");
  property p_blocked_off;
    !beams_clear [*3] |-> !safety_output_pair;
  endproperty
  a_blocked_off: assert property (p_blocked_off)
    else $error("outputs on with beams interrupted");
  property p_fail_off;
    failure_present [*3] |-> !safety_output_pair;
  endproperty
  a_fail_off: assert property (p_fail_off)
    else $error("outputs on during a failure");
  property p_nv_pulse;
    range_nv_wr |=> !range_nv_wr;
  endproperty
  a_nv_pulse: assert property (p_nv_pulse)
    else $error("range store strobe longer than one cycle");
  property p_nv_match;
    range_nv_wr |-> ##[0:2] (range_long == range_nv_out);
  endproperty
  a_nv_match: assert property (p_nv_match)
    else $error("stored range differs from active range");
  c_read: cover property (bus.rd ##1 rdata != 32'h0);
  c_irq: cover property ($rose(irq));
  c_code: cover property (emission_code_one == LCS_CODE_TWO);
endmodule
`default_nettype wire

//--- testbench/lcs_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module lcs_control_tb;
  import lcs_pkg::*;
  logic clk_sys, rst, reset_in, test_in, restart_in, beams_clear;
  logic failure_present, feedback_nc, range_nv_in, range_nv_out;
  logic range_nv_wr, safety_output_pair, emission_en, range_long;
  logic irq, stuck_closed;
  logic [31:0] rdata, d;
  lcs_bus_t bus;
  lcs_code_pin_t code_pin;
  lcs_code_t emission_code_one;
  lcs_code_t codes [3] = '{LCS_CODE_ONE, LCS_CODE_NONE, LCS_CODE_TWO};
  lcs_code_pin_t pins [3] = '{2'b10, 2'b00, 2'b01};
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_store = 0;
  // Short time base: two clock cycles per millisecond
  localparam int unsigned TICK = 2;
  // ------------------------------------------------------------
  // Design and relay
  // ------------------------------------------------------------
  lcs_control #(.TICK_CYCLES(TICK)) i_lcs_control (.clk_sys(clk_sys),
    .rst(rst), .bus(bus),
    .rdata(rdata), .reset_in(reset_in), .test_in(test_in),
    .restart_in(restart_in), .code_pin(code_pin),
    .beams_clear(beams_clear), .failure_present(failure_present),
    .feedback_nc(feedback_nc), .range_nv_in(range_nv_in),
    .range_nv_out(range_nv_out), .range_nv_wr(range_nv_wr),
    .safety_output_pair(safety_output_pair), .emission_en(emission_en),
    .range_long(range_long), .emission_code_one(emission_code_one),
    .irq(irq));
  lcs_relay_model i_lcs_relay_model (.clk_sys(clk_sys),
    .safety_output_pair(safety_output_pair),
    .stuck_closed(stuck_closed), .feedback_nc(feedback_nc));
  // Clock and run limit
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 62000) begin
      failures++;
      end_of_test();
    end
  end
  // Count range store strobes away from the launching edge
  always @(negedge clk_sys) begin
    if (range_nv_wr === 1'b1) begin
      n_store++;
    end
  end
  // ------------------------------------------------------------
  // Access and compare tasks
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus <= '0;
    #1 v = rdata;
  endtask
  task automatic chk_word(input logic [31:0] got, exp, mask);
    n_tests++;
    if ((got & mask) !== (exp & mask)) begin
      failures++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, exp);
    chk_word({31'h0, got}, {31'h0, exp}, 32'h1);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
  endtask
  // Hold {reset_in, test_in, restart_in} for a number of milliseconds
  task automatic hold_in(input logic [2:0] sel, input int ms);
    {reset_in, test_in, restart_in} <= sel;
    repeat (ms * TICK) @(posedge clk_sys);
    {reset_in, test_in, restart_in} <= 3'h0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic wait_ms(input int ms);
    repeat (ms * TICK) @(posedge clk_sys);
    #1;
  endtask
  task automatic end_of_test();
    $display("comparisons %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    rst = 1'b1;
    bus = '0;
    {reset_in, test_in, restart_in, beams_clear} = 4'h0;
    {failure_present, range_nv_in, stuck_closed} = 3'h0;
    code_pin = '0;
    // Each code setting, and a stored range, taken once at startup
    for (int i = 0; i < 3; i++) begin
      code_pin <= pins[i];
      range_nv_in <= i[0];
      do_reset();
      code_pin <= pins[(i + 1) % 3];
      rd(ADDR_STATUS, d);
      chk_word(d, {24'h0, codes[i], i[0], 5'h0}, 32'hFFFF_FFF8);
      chk_bit(range_long, i[0]);
      chk_word({30'h0, emission_code_one}, {30'h0, codes[i]}, 32'h3);
    end
    // Register access, unmapped and read-only places
    rd(ADDR_CTRL, d);
    chk_word(d, CTRL_RESET, 32'hFFFF_FFFF);
    wr(ADDR_CTRL, 32'h0000_0005);
    rd(ADDR_CTRL, d);
    chk_word(d, 32'h0000_0005, 32'h0000_000F);
    rd(8'h14, d);
    chk_word(d, 32'h0, 32'hFFFF_FFFF);
    wr(ADDR_IRQ_CLR, 32'h0000_001F);
    wr(ADDR_IRQ_STAT, 32'h0000_001F);
    rd(ADDR_IRQ_STAT, d);
    chk_word(d, 32'h0, 32'hFFFF_FFFF);
    // Failure still present at startup locks again
    failure_present <= 1'b1;
    do_reset();
    rd(ADDR_STATUS, d);
    chk_word(d, 32'h2, 32'h3);
    chk_bit(safety_output_pair, 1'b0);
    rd(ADDR_IRQ_STAT, d);
    chk_word(d, 32'h1 << EV_LOCK, 32'h1 << EV_LOCK);
    chk_bit(irq, 1'b0);
    // Interrupt raised, masked and cleared
    wr(ADDR_IRQ_EN, 32'h0000_001F);
    repeat (2) @(posedge clk_sys);
    #1 chk_bit(irq, 1'b1);
    wr(ADDR_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk_sys);
    #1 chk_bit(irq, 1'b0);
    failure_present <= 1'b0;
    wr(ADDR_IRQ_EN, 32'h0000_001F);
    wr(ADDR_IRQ_CLR, 32'h0000_001F);
    repeat (2) @(posedge clk_sys);
    #1 chk_bit(irq, 1'b0);
    rd(ADDR_IRQ_STAT, d);
    chk_word(d, 32'h0, 32'h1 << EV_LOCK);
    // Short holds change neither lock nor range
    hold_in(3'b100, 1000);
    rd(ADDR_STATUS, d);
    chk_word(d, 32'h2, 32'h3);
    hold_in(3'b010, 1000);
    chk_bit(range_long, 1'b0);
    // Reset held past the upper limit stays locked
    hold_in(3'b100, 10050);
    rd(ADDR_STATUS, d);
    chk_word(d, 32'h2, 32'h3);
    // Reset held inside the window returns to run
    hold_in(3'b100, 5100);
    rd(ADDR_STATUS, d);
    chk_word(d, 32'h1, 32'h3);
    // Automatic restart with contactor monitoring on
    wr(ADDR_CTRL, 32'h0000_0001);
    beams_clear <= 1'b1;
    wait_ms(120);
    chk_bit(safety_output_pair, 1'b1);
    wait_ms(400);
    rd(ADDR_STATUS, d);
    chk_word(d, 32'hD, 32'hF);
    // Test input stops emission and drops the outputs
    test_in <= 1'b1;
    wait_ms(600);
    chk_bit(emission_en, 1'b0);
    chk_bit(safety_output_pair, 1'b0);
    test_in <= 1'b0;
    wait_ms(150);
    chk_bit(safety_output_pair, 1'b1);
    rd(ADDR_IRQ_STAT, d);
    chk_word(d, 32'h1 << EV_TEST, 32'h1 << EV_TEST);
    // Manual restart waits for a held restart press
    wr(ADDR_CTRL, 32'h0000_0003);
    beams_clear <= 1'b0;
    wait_ms(10);
    beams_clear <= 1'b1;
    wait_ms(150);
    chk_bit(safety_output_pair, 1'b0);
    hold_in(3'b001, 600);
    chk_bit(safety_output_pair, 1'b1);
    // Range toggled by a test hold between the two limits
    wr(ADDR_CTRL, 32'h0000_0009);
    hold_in(3'b010, 3000);
    chk_bit(range_long, 1'b1);
    chk_bit(range_nv_out, 1'b1);
    chk_word(n_store, 32'h1, 32'hFFFF_FFFF);
    // Feedback contact stuck closed forces a lockout
    wait_ms(500);
    stuck_closed <= 1'b1;
    beams_clear <= 1'b0;
    wait_ms(150);
    beams_clear <= 1'b1;
    wait_ms(500);
    chk_bit(safety_output_pair, 1'b0);
    rd(ADDR_STATUS, d);
    chk_word(d, 32'h2, 32'h3);
    rd(ADDR_IRQ_STAT, d);
    chk_word(d, 32'h1 << EV_FB_FAULT, 32'h1 << EV_FB_FAULT);
    // Power cycle clears it; a critical lock ignores the reset input
    stuck_closed <= 1'b0;
    do_reset();
    rd(ADDR_STATUS, d);
    chk_word(d, 32'h1, 32'h3);
    wr(ADDR_CTRL, 32'h0000_0004);
    failure_present <= 1'b1;
    repeat (4) @(posedge clk_sys);
    failure_present <= 1'b0;
    hold_in(3'b100, 5100);
    rd(ADDR_STATUS, d);
    chk_word(d, 32'h12, 32'h13);
    end_of_test();
  end
endmodule
bind lcs_control lcs_control_assertions #(.TICK_CYCLES(TICK_CYCLES))
  i_lcs_control_assertions (
  .clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
  .beams_clear(beams_clear), .failure_present(failure_present),
  .range_nv_out(range_nv_out), .range_nv_wr(range_nv_wr),
  .safety_output_pair(safety_output_pair), .range_long(range_long),
  .emission_code_one(emission_code_one), .irq(irq));
`default_nettype wire

//--- testbench/lcs_relay_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Force-guided relay with normally closed feedback contact
// ------------------------------------------------------------
module lcs_relay_model #(
  parameter int unsigned DELAY = 20
) (
  input wire logic clk_sys,
  input wire logic safety_output_pair,
  input wire logic stuck_closed,
  output logic feedback_nc
);
  logic coil_reg = 1'b0;
  logic nc_reg = 1'b1;
  int cnt = 0;
  assign feedback_nc = nc_reg;
  // Contact follows the coil after a mechanical delay
  always @(posedge clk_sys) begin
    if (safety_output_pair !== coil_reg) begin
      coil_reg <= safety_output_pair;
      cnt <= 0;
    end else if (cnt < DELAY) begin
      cnt <= cnt + 1;
    end else begin
      nc_reg <= !coil_reg || stuck_closed;
    end
  end
endmodule
`default_nettype wire
